/* src/cod_clock_out_ctrl.v */
// Clock output chain control: level loop, dividers, sync, output buffers
//
// What this block does
// - Level loop runs during each tuning cycle.
// - Force-on keeps loop always on, overriding others.
// - Unlock-enable runs loop while PLL unlocked.
// - Watch-only monitors amplitude, does not start loop.
// - Amplitude flags valid only when loop/watch active.
// - Feedback ratio 32 to 1023, normal mode.
// - Feedback ratio 2 to 511, aligned mode.
// - Prescaler divides 2/2.5/3/3.5/4, feeds all outputs.
// - Ratio two or integer prescale gives 50%.
// - Ratio one, half prescale: 40%/57% duty.
// - Ratio codes 0-15 map 1 to 512.
// - Power modes: run, tune mute, buffer off, off.
// - Output 0 mode 1 powers down if aligned.
// - Aligned mode puts output 0 in feedback.
// - Start delayed by 0-255 prescaler periods.
// - Delay needs resync allow; not output 0 aligned.
// - Polarity flip inverts differential sense.
// - Silence holds logic 0 per polarity flip.
// - Aligned mode ignores silence of output 0.
// - Restart after feedback cycle, 18 prescaler, delay.
`timescale 1ns/1ps
`include "cod_defs.vh"
module cod_clock_out_ctrl
#(
   parameter NOUT = 5
)
(
   // Clock and reset
   input  wire                    core_clk,
   input  wire                    rst,
   // Register port
   input  wire [`COD_ADDR_W-1:0]  reg_addr,
   input  wire [`COD_DATA_W-1:0]  reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [`COD_DATA_W-1:0]  reg_rdata,
   // Pins from analog side and outside
   input  wire                    pll_locked_pin,
   input  wire                    amp_high_pin,
   input  wire                    amp_low_pin,
   input  wire                    sync_pin,
   // Amplitude loop controls
   output reg                     amplitude_control_loop,
   output reg                     amplitude_monitor_on,
   // Feedback divider
   output reg                     fb_tick,
   // Clock outputs
   output reg  [NOUT-1:0]         out_p,
   output reg  [NOUT-1:0]         out_n,
   output reg  [NOUT-1:0]         out_on
);

   localparam ST_IDLE = 4'b0001;
   localparam ST_HOLD = 4'b0010;
   localparam ST_FB   = 4'b0100;
   localparam ST_P    = 4'b1000;

   reg  [7:0]       loop_ctrl;
   reg  [9:0]       feedback_divide_value;
   reg  [2:0]       prescale_select;
   reg              sw_sync;
   reg  [NOUT-1:0]  divider_resync_allow;
   reg  [NOUT-1:0]  output_polarity_flip;
   reg  [NOUT-1:0]  output_silence;
   reg  [5:0]       out_cfg [0:NOUT-1];
   reg  [7:0]       output_start_delay [0:NOUT-1];

   reg  [3:0]       pin_s1;
   reg  [3:0]       pin_s2;
   wire             locked;
   wire             amp_hi;
   wire             amp_lo;
   wire             sync_in;

   reg              tuning;
   reg  [15:0]      tune_cnt;
   reg              amplitude_high_flag;
   reg              amplitude_low_flag;
   wire             level_loop_on_tuning;
   wire             level_loop_force_on;
   wire             level_loop_on_unlock;
   wire             amplitude_watch_only;
   wire             reference_aligned_mode;
   wire             next_loop;
   wire             enable_missing;

   reg  [2:0]       p_cnt;
   reg              p_tick;
   reg              p_level;
   reg  [9:0]       fb_cnt;
   wire [2:0]       p_len;
   wire [2:0]       p_high;
   wire             fb_bad;
   wire [9:0]       fb_eff;
   wire             fb_step;

   reg  [3:0]       sync_state;
   reg  [4:0]       sync_cnt;
   reg              restart;
   wire             sync_req;

   wire [NOUT-1:0]  ch_p;
   wire [NOUT-1:0]  ch_n;
   wire [NOUT-1:0]  ch_on;
   wire [NOUT-1:0]  ch_cyc;

   reg  [7:0]       next_rdata;
   integer          i;

   // Prescaler period in core cycles; one core cycle is half a VCO period
   function [2:0] pre_len;
      input [2:0] sel;
      pre_len = (sel > 3'h4) ? 3'h4 : sel + 3'h4;
   endfunction

   // High time of the prescaler waveform in core cycles
   function [2:0] pre_high;
      input [2:0] sel;
      case (sel)
         3'h0:    pre_high = 3'h2;
         3'h1:    pre_high = 3'h2;
         3'h2:    pre_high = 3'h3;
         3'h3:    pre_high = 3'h4;
         3'h4:    pre_high = 3'h4;
         default: pre_high = 3'h2;
      endcase
   endfunction

   assign level_loop_on_tuning   = loop_ctrl[`COD_BIT_ON_TUNING];
   assign level_loop_force_on    = loop_ctrl[`COD_BIT_FORCE_ON];
   assign level_loop_on_unlock   = loop_ctrl[`COD_BIT_ON_UNLOCK];
   assign amplitude_watch_only   = loop_ctrl[`COD_BIT_WATCH_ONLY];
   assign reference_aligned_mode = loop_ctrl[`COD_BIT_REF_ALIGN];

   assign locked  = pin_s2[0];
   assign amp_hi  = pin_s2[1];
   assign amp_lo  = pin_s2[2];
   assign sync_in = pin_s2[3];

   // Register writes
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         loop_ctrl             <= `COD_LOOP_CTRL_RST;
         feedback_divide_value <= `COD_FB_RST;
         prescale_select       <= `COD_PRESCALE_RST;
         sw_sync               <= 1'b0;
         divider_resync_allow  <= {NOUT{1'b0}};
         output_polarity_flip  <= {NOUT{1'b0}};
         output_silence        <= {NOUT{1'b0}};
         for (i = 0; i < NOUT; i = i + 1)
         begin
            out_cfg[i]            <= `COD_OUT_CFG_RST;
            output_start_delay[i] <= 8'h00;
         end
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `COD_REG_LOOP_CTRL: loop_ctrl <= {3'h0, reg_wdata[4:0]};
            `COD_REG_FB_LO:     feedback_divide_value[7:0] <= reg_wdata;
            `COD_REG_FB_HI:     feedback_divide_value[9:8] <= reg_wdata[1:0];
            `COD_REG_PRESCALE:  prescale_select <= reg_wdata[2:0];
            `COD_REG_SYNC:      sw_sync <= reg_wdata[0];
            `COD_REG_RESYNC:    divider_resync_allow <= reg_wdata[NOUT-1:0];
            `COD_REG_FLIP:      output_polarity_flip <= reg_wdata[NOUT-1:0];
            `COD_REG_SILENCE:   output_silence <= reg_wdata[NOUT-1:0];
            default:
            begin
               for (i = 0; i < NOUT; i = i + 1)
               begin
                  if (reg_addr == `COD_REG_OUT_CFG0 + i[5:0])
                     out_cfg[i] <= reg_wdata[5:0];
                  if (reg_addr == `COD_REG_OUT_DLY0 + i[5:0])
                     output_start_delay[i] <= reg_wdata;
               end
            end
         endcase
      end
   end

   // Register reads, answered in the following cycle
   always @*
   begin
      next_rdata = 8'h00;
      case (reg_addr)
         `COD_REG_LOOP_CTRL: next_rdata = {2'h0, tuning, loop_ctrl[4:0]};
         `COD_REG_STATUS:    next_rdata = {1'b0, enable_missing, fb_bad,
                                           sync_state != ST_IDLE, tuning,
                                           amplitude_control_loop,
                                           amplitude_low_flag,
                                           amplitude_high_flag};
         `COD_REG_FB_LO:     next_rdata = feedback_divide_value[7:0];
         `COD_REG_FB_HI:     next_rdata = {6'h00, feedback_divide_value[9:8]};
         `COD_REG_PRESCALE:  next_rdata = {5'h00, prescale_select};
         `COD_REG_SYNC:      next_rdata = {7'h00, sw_sync};
         `COD_REG_RESYNC:    next_rdata = {3'h0, divider_resync_allow};
         `COD_REG_FLIP:      next_rdata = {3'h0, output_polarity_flip};
         `COD_REG_SILENCE:   next_rdata = {3'h0, output_silence};
         default:
         begin
            for (i = 0; i < NOUT; i = i + 1)
            begin
               if (reg_addr == `COD_REG_OUT_CFG0 + i[5:0])
                  next_rdata = {2'h0, out_cfg[i]};
               if (reg_addr == `COD_REG_OUT_DLY0 + i[5:0])
                  next_rdata = output_start_delay[i];
            end
         end
      endcase
   end

   always @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
   end

   // Two-flop synchronisers on all pin inputs
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end
      else
      begin
         pin_s1 <= {sync_pin, amp_low_pin, amp_high_pin, pll_locked_pin};
         pin_s2 <= pin_s1;
      end
   end

   // Tuning cycle, started by the self-clearing start bit
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         tuning   <= 1'b0;
         tune_cnt <= 16'h0000;
      end
      else if (reg_wr & (reg_addr == `COD_REG_LOOP_CTRL) &
               reg_wdata[`COD_BIT_TUNE_START])
      begin
         tuning   <= 1'b1;
         tune_cnt <= `COD_TUNE_CYC - 16'h0001;
      end
      else if (tuning)
      begin
         if (tune_cnt == 16'h0000)
            tuning <= 1'b0;
         else
            tune_cnt <= tune_cnt - 16'h0001;
      end
   end

   assign next_loop = level_loop_force_on |
                      (level_loop_on_tuning & tuning) |
                      (level_loop_on_unlock & ~locked);
   assign enable_missing = ~(level_loop_on_tuning | level_loop_force_on |
                             level_loop_on_unlock);

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         amplitude_control_loop <= 1'b0;
         amplitude_monitor_on   <= 1'b0;
         amplitude_high_flag    <= 1'b0;
         amplitude_low_flag     <= 1'b0;
      end
      else
      begin
         amplitude_control_loop <= next_loop;
         amplitude_monitor_on   <= next_loop | amplitude_watch_only;
         amplitude_high_flag    <= amp_hi & amplitude_monitor_on;
         amplitude_low_flag     <= amp_lo & amplitude_monitor_on;
      end
   end

   // Prescaler; invalid codes fall back to divide by 2
   assign p_len  = pre_len(prescale_select);
   assign p_high = pre_high(prescale_select);

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         p_cnt   <= 3'h0;
         p_tick  <= 1'b0;
         p_level <= 1'b0;
      end
      else
      begin
         p_cnt   <= (p_cnt == p_len - 3'h1) ? 3'h0 : p_cnt + 3'h1;
         p_tick  <= (p_cnt == 3'h0);
         p_level <= (p_cnt < p_high);
      end
   end

   // Feedback divider; out-of-range ratios are clamped and flagged
   assign fb_bad = reference_aligned_mode ?
                   (feedback_divide_value < `COD_FB_RA_MIN ||
                    feedback_divide_value > `COD_FB_RA_MAX) :
                   (feedback_divide_value < `COD_FB_MIN);
   assign fb_eff = ~fb_bad ? feedback_divide_value :
                   reference_aligned_mode ?
                   ((feedback_divide_value < `COD_FB_RA_MIN) ?
                    `COD_FB_RA_MIN : `COD_FB_RA_MAX) : `COD_FB_MIN;
   // Aligned mode counts output 0 periods, otherwise VCO half periods
   assign fb_step = reference_aligned_mode ? ch_cyc[0] : 1'b1;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         fb_cnt  <= 10'h000;
         fb_tick <= 1'b0;
      end
      else
      begin
         fb_tick <= 1'b0;
         if (fb_step)
         begin
            if (fb_cnt >= fb_eff - 10'h001)
            begin
               fb_cnt  <= 10'h000;
               fb_tick <= 1'b1;
            end
            else
               fb_cnt <= fb_cnt + 10'h001;
         end
      end
   end

   // Sync sequencer: hold, one feedback cycle, 18 prescaler periods
   assign sync_req = sync_in | sw_sync;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         sync_state <= ST_IDLE;
         sync_cnt   <= 5'h00;
         restart    <= 1'b0;
      end
      else
      begin
         restart <= 1'b0;
         case (sync_state)
            ST_IDLE:
               if (sync_req)
                  sync_state <= ST_HOLD;
            ST_HOLD:
               if (~sync_req)
                  sync_state <= ST_FB;
            ST_FB:
               if (sync_req)
                  sync_state <= ST_HOLD;
               else if (fb_tick)
               begin
                  sync_state <= ST_P;
                  sync_cnt   <= `COD_RESTART_P;
               end
            ST_P:
               if (sync_req)
                  sync_state <= ST_HOLD;
               else if (p_tick)
               begin
                  if (sync_cnt == 5'h01)
                  begin
                     sync_state <= ST_IDLE;
                     restart    <= 1'b1;
                  end
                  sync_cnt <= sync_cnt - 5'h01;
               end
            default:
               sync_state <= ST_IDLE;
         endcase
      end
   end

   // Output channels
   genvar g;
   generate
      for (g = 0; g < NOUT; g = g + 1)
      begin : chan
         wire ra0   = reference_aligned_mode & (g == 0);
         wire allow = divider_resync_allow[g] & ~ra0;
         wire mute1 = tuning & (out_cfg[g][5:4] == `COD_MODE_TUNE_MUTE);
         cod_out_chan u_chan
         (
            .core_clk    (core_clk),
            .rst         (rst),
            .p_tick      (p_tick),
            .p_level     (p_level),
            .ratio_code  (out_cfg[g][3:0]),
            .power_mode  (out_cfg[g][5:4]),
            .start_delay (output_start_delay[g]),
            .delay_on    (allow),
            .flip        (output_polarity_flip[g]),
            .silence     (output_silence[g] & ~ra0),
            .tune_mute   (mute1 & ~ra0),
            .tune_pdown  (mute1 & ra0),
            .hold        (allow & (sync_state != ST_IDLE) & ~restart),
            .restart     (restart & allow),
            .out_p       (ch_p[g]),
            .out_n       (ch_n[g]),
            .out_on      (ch_on[g]),
            .cyc_tick    (ch_cyc[g])
         );
      end
   endgenerate

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         out_p  <= {NOUT{1'b0}};
         out_n  <= {NOUT{1'b0}};
         out_on <= {NOUT{1'b0}};
      end
      else
      begin
         out_p  <= ch_p;
         out_n  <= ch_n;
         out_on <= ch_on;
      end
   end

endmodule // cod_clock_out_ctrl

/* src/cod_defs.vh */
// Register map, field positions, reset values and timing counts
`ifndef COD_DEFS_VH
`define COD_DEFS_VH

`define COD_ADDR_W          6
`define COD_DATA_W          8

`define COD_REG_LOOP_CTRL   6'h00
`define COD_REG_STATUS      6'h01
`define COD_REG_FB_LO       6'h02
`define COD_REG_FB_HI       6'h03
`define COD_REG_PRESCALE    6'h04
`define COD_REG_SYNC        6'h05
`define COD_REG_RESYNC      6'h06
`define COD_REG_FLIP        6'h07
`define COD_REG_SILENCE     6'h08
`define COD_REG_OUT_CFG0    6'h10
`define COD_REG_OUT_DLY0    6'h18

`define COD_BIT_ON_TUNING   0
`define COD_BIT_FORCE_ON    1
`define COD_BIT_ON_UNLOCK   2
`define COD_BIT_WATCH_ONLY  3
`define COD_BIT_REF_ALIGN   4
`define COD_BIT_TUNE_START  5

`define COD_LOOP_CTRL_RST   8'h01
`define COD_FB_RST          10'h020
`define COD_FB_MIN          10'h020
`define COD_FB_RA_MIN       10'h002
`define COD_FB_RA_MAX       10'h1ff
`define COD_PRESCALE_RST    3'h0
`define COD_OUT_CFG_RST     6'h00
`define COD_MODE_RUN        2'h0
`define COD_MODE_TUNE_MUTE  2'h1
`define COD_MODE_BUF_OFF    2'h2
`define COD_MODE_ALL_OFF    2'h3

`define COD_RESTART_P       5'h12
`define COD_TUNE_CYC        16'h0040

`endif

/* src/cod_out_chan.v */
// One output divider with start delay, power modes, silence and polarity
`timescale 1ns/1ps
module cod_out_chan
(
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // Prescaler timing
   input  wire       p_tick,
   input  wire       p_level,
   // Configuration
   input  wire [3:0] ratio_code,
   input  wire [1:0] power_mode,
   input  wire [7:0] start_delay,
   input  wire       delay_on,
   input  wire       flip,
   input  wire       silence,
   input  wire       tune_mute,
   input  wire       tune_pdown,
   // Synchronisation
   input  wire       hold,
   input  wire       restart,
   // Outputs
   output reg        out_p,
   output reg        out_n,
   output reg        out_on,
   output reg        cyc_tick
);

   reg  [7:0] dly_cnt;
   reg        dly_run;
   reg        running;
   reg  [8:0] cnt;
   reg        lvl;
   wire [8:0] half;
   wire       wave;
   wire       div_off;
   wire       buf_on;
   wire       quiet;

   // Half the division ratio, in prescaler periods
   function [8:0] half_ratio;
      input [3:0] code;
      case (code)
         4'h1:    half_ratio = 9'h001;
         4'h2:    half_ratio = 9'h002;
         4'h3:    half_ratio = 9'h004;
         4'h4:    half_ratio = 9'h006;
         4'h5:    half_ratio = 9'h008;
         4'h6:    half_ratio = 9'h00c;
         4'h7:    half_ratio = 9'h010;
         4'h8:    half_ratio = 9'h018;
         4'h9:    half_ratio = 9'h020;
         4'ha:    half_ratio = 9'h030;
         4'hb:    half_ratio = 9'h040;
         4'hc:    half_ratio = 9'h060;
         4'hd:    half_ratio = 9'h080;
         4'he:    half_ratio = 9'h0c0;
         4'hf:    half_ratio = 9'h100;
         default: half_ratio = 9'h000;
      endcase
   endfunction

   assign half    = half_ratio(ratio_code);
   assign div_off = (power_mode == `COD_MODE_ALL_OFF);
   assign wave    = (ratio_code == 4'h0) ? (p_level & running) : lvl;
   assign buf_on  = ~div_off & (power_mode != `COD_MODE_BUF_OFF) & ~tune_pdown;
   assign quiet   = silence | tune_mute;

   always @(posedge core_clk)
   begin
      if (rst | div_off | hold)
      begin
         dly_cnt  <= 8'h00;
         dly_run  <= 1'b0;
         running  <= ~hold;
         cnt      <= 9'h000;
         lvl      <= 1'b0;
         cyc_tick <= 1'b0;
      end
      else
      begin
         cyc_tick <= 1'b0;
         if (restart)
         begin
            running <= 1'b0;
            lvl     <= 1'b0;
            cnt     <= 9'h000;
            dly_cnt <= delay_on ? start_delay : 8'h00;
            dly_run <= 1'b1;
         end
         else if (dly_run)
         begin
            if (dly_cnt == 8'h00)
            begin
               dly_run <= 1'b0;
               running <= 1'b1;
               lvl     <= 1'b1;
               cyc_tick <= 1'b1;
            end
            else if (p_tick)
               dly_cnt <= dly_cnt - 8'h01;
         end
         else if (running & p_tick)
         begin
            if (half == 9'h000)
               cyc_tick <= 1'b1;
            else if (cnt >= half - 9'h001)
            begin
               cnt      <= 9'h000;
               lvl      <= ~lvl;
               cyc_tick <= ~lvl;
            end
            else
               cnt <= cnt + 9'h001;
         end
      end
   end

   // Buffer: silenced output is logic 0 in the flipped sense
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         out_p  <= 1'b0;
         out_n  <= 1'b0;
         out_on <= 1'b0;
      end
      else
      begin
         out_on <= buf_on;
         out_p  <= buf_on & (quiet ? flip : (wave ^ flip));
         out_n  <= buf_on & (quiet ? ~flip : ~(wave ^ flip));
      end
   end

endmodule // cod_out_chan

/* verif/cod_chk.sv */
// Port checker for the clock output controller
`timescale 1ns/1ps
module cod_chk
#(
   parameter NOUT = 5
)
(
   // Clock, reset and register port
   input wire            core_clk,
   input wire            rst,
   input wire [5:0]      reg_addr,
   input wire [7:0]      reg_wdata,
   input wire            reg_wr,
   input wire            reg_rd,
   input wire [7:0]      reg_rdata,
   // Pins and outputs
   input wire            pll_locked_pin,
   input wire            amplitude_control_loop,
   input wire            amplitude_monitor_on,
   input wire            fb_tick,
   input wire [NOUT-1:0] out_p,
   input wire [NOUT-1:0] out_n,
   input wire [NOUT-1:0] out_on
);
   reg  [7:0]      ctl;
   reg  [NOUT-1:0] flp;
   reg  [NOUT-1:0] sil;
   reg  [2:0]      cnt;
   wire [NOUT-1:0] m;
   // Output 0 left out: aligned mode may ignore its silence
   assign m = sil & out_on & ~{{(NOUT-1){1'b0}}, 1'b1};
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         ctl <= 8'h01;
         flp <= {NOUT{1'b0}};
         sil <= {NOUT{1'b0}};
         cnt <= 3'h0;
      end
      else
      begin
         if (reg_wr && reg_addr == 6'h00)
            ctl <= reg_wdata;
         if (reg_wr && reg_addr == 6'h07)
            flp <= reg_wdata[NOUT-1:0];
         if (reg_wr && reg_addr == 6'h08)
            sil <= reg_wdata[NOUT-1:0];
         if (reg_wr)
            cnt <= 3'h0;
         else if (cnt != 3'h4)
            cnt <= cnt + 3'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   mon_covers_loop_a: assert property (
      amplitude_control_loop |-> amplitude_monitor_on)
      else $error("monitor off while loop on");
   legs_off_a: assert property ((~out_on & (out_p | out_n)) == 0)
      else $error("leg driven while buffer off");
   force_on_a: assert property (
      ctl[1] [*3] |-> amplitude_control_loop)
      else $error("loop off while forced on");
   unlock_loop_a: assert property (
      (ctl[2] && !pll_locked_pin) [*6] |-> amplitude_control_loop)
      else $error("loop off while unlocked");
   no_enable_a: assert property (
      (ctl[2:0] == 3'h0) [*5] |-> !amplitude_control_loop)
      else $error("loop on without enable");
   watch_only_a: assert property (
      (ctl[3:0] == 4'h8) [*5]
      |-> amplitude_monitor_on && !amplitude_control_loop)
      else $error("watch only mode wrong");
   flags_masked_a: assert property (
      $past(reg_rd) && $past(reg_addr) == 6'h01
      && !$past(amplitude_monitor_on) && !$past(amplitude_monitor_on, 2)
      |-> reg_rdata[1:0] == 2'h0)
      else $error("flag while masked");
   silence_pos_a: assert property (
      cnt == 3'h4 |-> ((out_p ^ flp) & m) == 0)
      else $error("muted p leg");
   silence_neg_a: assert property (
      cnt == 3'h4 |-> ((out_n ^ ~flp) & m) == 0)
      else $error("muted n leg");
   fb_pulse_a: assert property (fb_tick |=> !fb_tick)
      else $error("feedback tick too long");
endmodule // cod_chk

bind cod_clock_out_ctrl cod_chk #(.NOUT(NOUT)) i_cod_chk
(
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pll_locked_pin(pll_locked_pin),
   .amplitude_control_loop(amplitude_control_loop),
   .amplitude_monitor_on(amplitude_monitor_on), .fb_tick(fb_tick),
   .out_p(out_p), .out_n(out_n), .out_on(out_on)
);

/* verif/cod_load_model.sv */
// Clock load measuring period and high time of one output
`timescale 1ns/1ps
module cod_load_model
(
   // Clock and observed legs
   input  wire        core_clk,
   input  wire [4:0]  out_p,
   input  wire [2:0]  sel,
   // Measurements
   output reg  [15:0] per,
   output reg  [15:0] hi
);
   reg [15:0] cnt;
   reg [15:0] hcnt;
   reg        prev;
   always @(posedge core_clk)
   begin
      prev <= out_p[sel];
      if (out_p[sel] && !prev)
      begin
         per <= cnt;
         hi <= hcnt;
         cnt <= 16'h0001;
         hcnt <= 16'h0001;
      end
      else
      begin
         cnt <= cnt + 16'h0001;
         hcnt <= hcnt + {15'h0000, out_p[sel]};
      end
   end
endmodule // cod_load_model

/* verif/cod_clock_out_ctrl_tb.sv */
// Self-checking bench for the clock output controller
`timescale 1ns/1ps
module cod_clock_out_ctrl_tb;
   localparam [159:0] RT = {10'd512, 10'd384, 10'd256, 10'd192, 10'd128,
      10'd96, 10'd64, 10'd48, 10'd32, 10'd24, 10'd16, 10'd12, 10'd8,
      10'd4, 10'd2, 10'd1};
   localparam [19:0] HT = {4'd4, 4'd4, 4'd3, 4'd2, 4'd2};
   reg         core_clk;
   reg         rst;
   reg  [5:0]  reg_addr;
   reg  [7:0]  reg_wdata;
   reg         reg_wr;
   reg         reg_rd;
   wire [7:0]  reg_rdata;
   reg         locked;
   reg         amp_hi;
   reg         amp_lo;
   reg         sync_pin;
   wire        loop_on;
   wire        mon_on;
   wire [4:0]  out_p;
   wire [4:0]  out_n;
   wire [4:0]  out_on;
   wire [15:0] per;
   wire [15:0] hi;
   reg  [31:0] seed;
   reg  [7:0]  rd_v;
   integer     err_total;
   integer     n_checks;
   integer     i;

   cod_clock_out_ctrl i_cod_clock_out_ctrl
   (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pll_locked_pin(locked),
      .amp_high_pin(amp_hi), .amp_low_pin(amp_lo), .sync_pin(sync_pin),
      .amplitude_control_loop(loop_on), .amplitude_monitor_on(mon_on),
      .fb_tick(), .out_p(out_p), .out_n(out_n), .out_on(out_on)
   );
   cod_load_model i_cod_load_model
   (
      .core_clk(core_clk), .out_p(out_p), .sel(3'h1), .per(per), .hi(hi)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction

   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got,
               exp);
         end
      end
   endtask

   task wr(input [5:0] a, input [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge core_clk);
         reg_wr <= 1'b0;
         @(posedge core_clk);
      end
   endtask

   task rd(input [5:0] a);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1 rd_v = reg_rdata;
         @(posedge core_clk);
      end
   endtask

   task wt(input integer n);
      repeat (n) @(posedge core_clk);
   endtask

   task fbchk(input [7:0] c, input [7:0] lo, input [7:0] h, input f);
      begin
         wr(6'h00, c);
         wr(6'h02, lo);
         wr(6'h03, h);
         wt(2);
         rd(6'h01);
         chk({15'h0, rd_v[5]}, {15'h0, f});
      end
   endtask

   // Output 1 period and high time
   task meas(input [2:0] p, input [3:0] r);
      reg [15:0] e;
      begin
         e = (16'd4 + p) * RT[r*10 +: 10];
         wr(6'h04, {5'h00, p});
         wr(6'h11, {4'h0, r});
         wt(3 * e + 20);
         chk(per, e);
         chk(hi, (r == 4'h0) ? {12'h0, HT[p*4 +: 4]} : e / 2);
      end
   endtask

   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial
   begin
      wt(60000);
      err_total = err_total + 1;
      final_report;
   end

   initial
   begin
      seed = 32'he9a5;
      err_total = 0;
      n_checks = 0;
      rst = 1'b1;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      locked = 1'b1;
      amp_hi = 1'b0;
      amp_lo = 1'b0;
      sync_pin = 1'b0;
      wt(3);
      rst <= 1'b0;
      rd(6'h00);
      chk(rd_v, 8'h01);
      rd(6'h02);
      chk(rd_v, 8'h20);
      rd(6'h3f);
      chk(rd_v, 8'h00);
      fbchk(8'h01, 8'h10, 8'h00, 1'b1);
      fbchk(8'h01, 8'hff, 8'h03, 1'b0);
      fbchk(8'h11, 8'h02, 8'h00, 1'b0);
      fbchk(8'h11, 8'h00, 8'h02, 1'b1);
      fbchk(8'h01, 8'h40, 8'h00, 1'b0);
      wr(6'h00, 8'h02);
      wt(4);
      chk({14'h0, loop_on, mon_on}, 16'h3);
      amp_hi <= 1'b1;
      wr(6'h00, 8'h08);
      wt(6);
      chk({14'h0, loop_on, mon_on}, 16'h1);
      rd(6'h01);
      chk(rd_v[0], 1'b1);
      wr(6'h00, 8'h01);
      wt(4);
      rd(6'h01);
      chk(rd_v[1:0], 2'h0);
      locked <= 1'b0;
      wr(6'h00, 8'h04);
      wt(6);
      chk(loop_on, 1'b1);
      locked <= 1'b1;
      wt(6);
      chk(loop_on, 1'b0);
      wr(6'h00, 8'h21);
      wt(4);
      chk(loop_on, 1'b1);
      wt(70);
      chk(loop_on, 1'b0);
      for (i = 0; i < 16; i = i + 1)
         meas(3'h0, i[3:0]);
      for (i = 0; i < 8; i = i + 1)
      begin
         seed = xs(seed);
         amp_lo <= seed[8];
         meas(seed[2:0] % 5, {2'h0, seed[5:4] % 3});
      end
      wr(6'h07, 8'h0a);
      wr(6'h08, 8'h1f);
      wt(8);
      chk({6'h0, out_p, out_n}, {6'h0, 5'h0a, 5'h15});
      wr(6'h08, 8'h00);
      wr(6'h07, 8'h00);
      wr(6'h06, 8'h02);
      sync_pin <= 1'b1;
      wt(20);
      chk(out_p[1], 1'b0);
      wt(30);
      chk(out_p[1], 1'b0);
      sync_pin <= 1'b0;
      wt(200);
      meas(3'h2, 4'h1);
      wr(6'h12, 8'h20);
      wr(6'h13, 8'h30);
      wt(8);
      chk(out_on, 5'h13);
      final_report;
   end
endmodule // cod_clock_out_ctrl_tb
